// File: bench/host_sleep_pins.sv
// host-side model of the two sleep pins
// assumes polarity inputs match the invert bits written to the control word
`default_nettype none
module host_sleep_pins
(
	input  wire logic want_p_i,
	input  wire logic want_s_i,
	input  wire logic pinv_i,
	input  wire logic sinv_i,
	output logic      pin_p_o,
	output logic      pin_s_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// a pin asserts by taking the level opposite its invert bit
	assign pin_p_o = want_p_i ^ pinv_i;
	assign pin_s_o = want_s_i ^ sinv_i;
endmodule
`default_nettype wire

// File: bench/sby_asserts.sv
// port checker for the standby and supply mode controller
// assumes it is bound to the top module and sees only its ports
`default_nettype none
module sby_asserts
(
	input wire logic              CLK_I,
	input wire logic              RST_N_I,
	input wire logic              PSEL_I,
	input wire logic              PENABLE_I,
	input wire logic              PWRITE_I,
	input wire logic              PREADY_O,
	input wire logic              PSLVERR_O,
	input wire logic              ABOVE_LOW_I,
	input wire logic              ABOVE_WEAK_I,
	input wire logic              ON_MODE_I,
	input wire logic [1:0]        BATTERY_THRESHOLD_SELECT_O,
	input wire logic              WEAK_BATTERY_INTERRUPT_O,
	input wire logic              LOW_BATTERY_INTERRUPT_O,
	input wire logic              DEEP_SLEEP_MODE_O,
	input wire logic              LOW_POWER_OFF_COMMAND_O,
	input wire logic [5:0]        LP_REG_ON_O,
	input wire logic [5:0]        LP_REG_LOW_POWER_O,
	input wire sby_pkg::sw_mode_t SW0_OP_O
);
	timeunit 1ns;
	timeprecision 1ps;
	import sby_pkg::*;
	wire wr_acc = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	// bus answer timing and error qualification
	a_ready_next: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("no ready after setup");
	a_err_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
	// battery events follow their comparator edges
	a_low_fall: assert property ($fell(ABOVE_LOW_I) |-> ##[1:3] LOW_BATTERY_INTERRUPT_O) else $error("low event missing");
	a_weak_cross: assert property ($changed(ABOVE_WEAK_I) && ABOVE_LOW_I && $stable(ABOVE_LOW_I)
		|-> ##[1:3] WEAK_BATTERY_INTERRUPT_O) else $error("weak event missing");
	a_low_only: assert property (LOW_BATTERY_INTERRUPT_O |-> !$past(ABOVE_LOW_I) && $past(ABOVE_LOW_I, 2))
		else $error("low event without a fall");
	a_weak_only: assert property (WEAK_BATTERY_INTERRUPT_O |-> $past(ABOVE_WEAK_I) != $past(ABOVE_WEAK_I, 2))
		else $error("weak event without a crossing");
	// sleep qualification
	a_off_mode: assert property (!ON_MODE_I [*2] |-> !DEEP_SLEEP_MODE_O) else $error("sleep outside on mode");
	a_lpoff_first: assert property (LOW_POWER_OFF_COMMAND_O [*2] |-> !DEEP_SLEEP_MODE_O) else $error("sleep over lpoff");
	a_sleep_cause: assert property ($rose(DEEP_SLEEP_MODE_O) |-> $past(ON_MODE_I) && !LOW_POWER_OFF_COMMAND_O)
		else $error("sleep without request");
	// supply state encodings and threshold select updates after writes
	a_reg_excl: assert property ((LP_REG_ON_O & LP_REG_LOW_POWER_O) == 6'h00) else $error("on and low-power");
	a_no_auto: assert property (SW0_OP_O != SW_AUTO) else $error("auto shown as op mode");
	a_bsel_write: assert property ($changed(BATTERY_THRESHOLD_SELECT_O) |-> $past(wr_acc) || $past(wr_acc, 2))
		else $error("select changed without write");
endmodule
bind standby_supply_mode_control sby_asserts u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.ABOVE_LOW_I(ABOVE_LOW_I), .ABOVE_WEAK_I(ABOVE_WEAK_I), .ON_MODE_I(ON_MODE_I),
	.BATTERY_THRESHOLD_SELECT_O(BATTERY_THRESHOLD_SELECT_O), .WEAK_BATTERY_INTERRUPT_O(WEAK_BATTERY_INTERRUPT_O),
	.LOW_BATTERY_INTERRUPT_O(LOW_BATTERY_INTERRUPT_O), .DEEP_SLEEP_MODE_O(DEEP_SLEEP_MODE_O),
	.LOW_POWER_OFF_COMMAND_O(LOW_POWER_OFF_COMMAND_O), .LP_REG_ON_O(LP_REG_ON_O),
	.LP_REG_LOW_POWER_O(LP_REG_LOW_POWER_O), .SW0_OP_O(SW0_OP_O));
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the standby and supply mode controller
// assumes the 100 MHz clock, APB register map and sleep timing of the design
`include "sby_cfg.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sby_pkg::*;
	localparam logic [63:0] NRM = 64'h3214_2214_0114_3210;
	localparam logic [63:0] SLP = 64'h3333_4224_0410_0000;
	logic        clk, rst_n, psel, pen, pwr, lo, wk, pon, on_mode, lp_off, slv;
	logic        want_p, want_s, pinv, sinv, pin_p, pin_s, pready, pslverr;
	logic        weak_irq, low_irq, deep, lpoff_cmd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  load_hi;
	logic [1:0]  bsel;
	logic [5:0]  lp_on, lp_low;
	logic [9:0]  simple_on;
	sw_mode_t    sw0, sw1, sw2, sw3;
	int          err_total, checked;
	host_sleep_pins host (.want_p_i(want_p), .want_s_i(want_s), .pinv_i(pinv), .sinv_i(sinv),
		.pin_p_o(pin_p), .pin_s_o(pin_s));
	standby_supply_mode_control dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .ABOVE_LOW_I(lo), .ABOVE_WEAK_I(wk), .ABOVE_PON_I(pon), .SLEEP_PIN_I(pin_p),
		.SECONDARY_SLEEP_PIN_I(pin_s), .ON_MODE_I(on_mode), .LP_OFF_STATE_I(lp_off), .LOAD_HIGH_I(load_hi),
		.BATTERY_THRESHOLD_SELECT_O(bsel), .WEAK_BATTERY_INTERRUPT_O(weak_irq),
		.LOW_BATTERY_INTERRUPT_O(low_irq), .DEEP_SLEEP_MODE_O(deep), .LOW_POWER_OFF_COMMAND_O(lpoff_cmd),
		.LP_REG_ON_O(lp_on), .LP_REG_LOW_POWER_O(lp_low), .SIMPLE_OUT_ON_O(simple_on),
		.SW0_OP_O(sw0), .SW1_OP_O(sw1), .SW2_OP_O(sw2), .SW3_OP_O(sw3));
	// free-running 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
			$display("Error at %0t: got %h expected %h", $time, g, e);
		if (g !== e)
			err_total++;
	endtask
	// one APB transfer: setup, then access until ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 20)
			ck(0, 1);
		if (n >= 20)
			end_of_test();
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0000_0000, r);
		ck(r, e);
	endtask
	task automatic lvl(input logic [2:0] v, input logic [31:0] e);
		{pon, wk, lo} <= v;
		repeat (4) @(posedge clk);
		rd(`ADDR_STATUS, e);
	endtask
	// battery status table and both event kinds
	task automatic t_battery;
		lvl(3'b111, 32'h0000_0003);
		wr(`ADDR_EVENTS, 32'h0000_0003);
		lvl(3'b011, 32'h0000_0002);
		lvl(3'b001, 32'h0000_0000);
		lvl(3'b000, 32'h0000_0004);
		rd(`ADDR_EVENTS, 32'h0000_0003);
		wr(`ADDR_EVENTS, 32'h0000_0003);
		lvl(3'b001, 32'h0000_0000);
		lvl(3'b111, 32'h0000_0003);
		rd(`ADDR_EVENTS, 32'h0000_0001);
	endtask
	// pin qualification, mode gating, exit and low-power-off priority
	task automatic t_sleep;
		on_mode <= 1'b1;
		pinv <= 1'b1;
		wr(`ADDR_CTRL, 32'h0000_0012);
		@(posedge clk);
		ck(bsel, 2);
		want_p <= 1'b1;
		repeat (4) @(posedge clk);
		ck(deep, 0);
		want_s <= 1'b1;
		repeat (4) @(posedge clk);
		ck(deep, 1);
		rd(`ADDR_STATUS, 32'h0000_001B);
		on_mode <= 1'b0;
		repeat (3) @(posedge clk);
		ck(deep, 0);
		on_mode <= 1'b1;
		repeat (4) @(posedge clk);
		want_p <= 1'b0;
		repeat (2) @(posedge clk);
		ck(deep, 0);
		wr(`ADDR_CTRL, 32'h0000_0052);
		want_p <= 1'b1;
		repeat (3) @(posedge clk);
		ck(deep, 0);
		ck(lpoff_cmd, 1);
	endtask
	// regulator and general output resolution in and out of sleep
	task automatic t_supply;
		wr(`ADDR_CTRL, 32'h0000_0010);
		wr(`ADDR_REG_EN, 32'h0000_FFFF);
		wr(`ADDR_REG_LP, 32'h0000_000A);
		wr(`ADDR_REG_SBY, 32'h0000_00F3);
		repeat (3) @(posedge clk);
		ck({lp_low, lp_on}, 12'h284);
		ck(simple_on, 10'h3FC);
		rd(`ADDR_REG_EN, 32'h0000_FFFF);
		rd(12'h0FC, 32'h0000_0000);
		ck(slv, 1);
		want_s <= 1'b0;
		repeat (3) @(posedge clk);
		ck({lp_low, lp_on}, 12'h2B5);
		ck(simple_on, 10'h3FF);
	endtask
	// every switcher code awake then asleep, auto by load, retention
	task automatic t_switch;
		logic [3:0] x;
		for (int s = 0; s < 2; s++)
			for (int c = 0; c < 16; c++)
			begin
				want_s <= s[0];
				wr(`ADDR_SW_MODE, c);
				repeat (3) @(posedge clk);
				x = s ? SLP[c*4 +: 4] : NRM[c*4 +: 4];
				ck(sw0, x == 4 ? 4'h2 : x);
				rd(`ADDR_SW_MODE, c);
			end
		load_hi <= 4'h0;
		wr(`ADDR_SW_MODE, 32'h0000_0008);
		repeat (3) @(posedge clk);
		ck(sw0, 3);
		wr(`ADDR_SW_MODE, 32'h0005_0001);
		lp_off <= 1'b1;
		repeat (3) @(posedge clk);
		ck({sw3, sw2, sw1, sw0}, 12'h0C3);
		lp_off <= 1'b0;
		wr(`ADDR_SW_MODE, 32'h0000_59D1);
		repeat (3) @(posedge clk);
		ck({sw3, sw2, sw1, sw0}, 12'h298);
	endtask
	// three-period entry delay, cancelled and restarted
	task automatic t_delay;
		int n;
		n = 0;
		want_s <= 1'b0;
		wr(`ADDR_CTRL, 32'h0000_001C);
		want_s <= 1'b1;
		repeat (4000) @(posedge clk);
		ck(deep, 0);
		want_s <= 1'b0;
		repeat (2) @(posedge clk);
		want_s <= 1'b1;
		while (deep !== 1'b1 && n < 12000)
		begin
			@(posedge clk);
			n++;
		end
		ck(n >= 6106 && n <= 9156, 1);
	endtask
	task automatic end_of_test;
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial
	begin
		{rst_n, psel, pen, pwr, lo, wk, pon, on_mode, lp_off} = '0;
		{want_p, want_s, pinv, sinv, slv} = '0;
		{paddr, pwdata} = '0;
		load_hi = 4'h1;
		err_total = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`ADDR_CTRL, 32'h0000_0004);
		ck(bsel, 0);
		t_battery();
		t_sleep();
		t_supply();
		t_switch();
		t_delay();
		end_of_test();
	end
endmodule
`default_nettype wire

// File: src/sby_cfg.svh
// constants for the standby and supply mode controller
// assumes a 100 MHz clock and 32-bit APB register access
`ifndef SBY_CFG_SVH
`define SBY_CFG_SVH

`define CLK_HZ          100000000
`define SLOW_HZ         32768
`define SLOW_DIV        (`CLK_HZ / `SLOW_HZ)

`define ADDR_CTRL       12'h000
`define ADDR_STATUS     12'h004
`define ADDR_EVENTS     12'h008
`define ADDR_REG_EN     12'h00C
`define ADDR_REG_LP     12'h010
`define ADDR_REG_SBY    12'h014
`define ADDR_SW_MODE    12'h018

`define CTRL_BSEL_LSB   0
`define CTRL_DLY_LSB    2
`define CTRL_PINV_BIT   4
`define CTRL_SINV_BIT   5
`define CTRL_LPOFF_BIT  6
`define CTRL_RESET      7'h04

`define EVT_WEAK_BIT    0
`define EVT_LOW_BIT     1

`define N_LP            6
`define N_ALL           16
`define N_SW            4
`define SW_RET_LSB      16

`endif

// File: src/sby_pkg.sv
// types for the standby and supply mode controller
// assumes nothing beyond the constants header
`default_nettype none
package sby_pkg;
	// switcher mode as programmed, before auto resolution
	typedef enum logic [2:0] {
		SW_OFF   = 3'b000,
		SW_PWM   = 3'b001,
		SW_SKIP  = 3'b010,
		SW_PFM   = 3'b011,
		SW_AUTO  = 3'b100
	} sw_mode_t;
	// sleep entry sequencing
	typedef enum logic [1:0] {
		ST_AWAKE = 2'b00,
		ST_WAIT  = 2'b01,
		ST_SLEEP = 2'b10
	} sby_state_t;
endpackage
`default_nettype wire

// File: src/standby_supply_mode_control.sv
// battery flags, sleep pin qualification and supply mode resolution
// assumes synchronous inputs on CLK_I and an APB master on the register port
`include "sby_cfg.svh"
`default_nettype none
module standby_supply_mode_control
(
	input  wire logic                    CLK_I,
	input  wire logic                    RST_N_I,
	input  wire logic                    PSEL_I,
	input  wire logic                    PENABLE_I,
	input  wire logic                    PWRITE_I,
	input  wire logic [11:0]             PADDR_I,
	input  wire logic [31:0]             PWDATA_I,
	output logic      [31:0]             PRDATA_O,
	output logic                         PREADY_O,
	output logic                         PSLVERR_O,
	input  wire logic                    ABOVE_LOW_I,
	input  wire logic                    ABOVE_WEAK_I,
	input  wire logic                    ABOVE_PON_I,
	input  wire logic                    SLEEP_PIN_I,
	input  wire logic                    SECONDARY_SLEEP_PIN_I,
	input  wire logic                    ON_MODE_I,
	input  wire logic                    LP_OFF_STATE_I,
	input  wire logic [`N_SW-1:0]        LOAD_HIGH_I,
	output logic      [1:0]              BATTERY_THRESHOLD_SELECT_O,
	output logic                         WEAK_BATTERY_INTERRUPT_O,
	output logic                         LOW_BATTERY_INTERRUPT_O,
	output logic                         DEEP_SLEEP_MODE_O,
	output logic                         LOW_POWER_OFF_COMMAND_O,
	output logic      [`N_LP-1:0]        LP_REG_ON_O,
	output logic      [`N_LP-1:0]        LP_REG_LOW_POWER_O,
	output logic      [`N_ALL-`N_LP-1:0] SIMPLE_OUT_ON_O,
	output sby_pkg::sw_mode_t            SW0_OP_O,
	output sby_pkg::sw_mode_t            SW1_OP_O,
	output sby_pkg::sw_mode_t            SW2_OP_O,
	output sby_pkg::sw_mode_t            SW3_OP_O
);
	import sby_pkg::*;

	// normal and sleep modes packed as {normal, sleep}
	// code 0111 has no defined meaning and is held off in both states
	function automatic logic [5:0] sw_decode(input logic [3:0] code);
		logic [5:0] r;
		r = {SW_OFF, SW_OFF};
		case (code)
			4'h0: r = {SW_OFF, SW_OFF};
			4'h1: r = {SW_PWM, SW_OFF};
			4'h2: r = {SW_SKIP, SW_OFF};
			4'h3: r = {SW_PFM, SW_OFF};
			4'h4: r = {SW_AUTO, SW_OFF};
			4'h5: r = {SW_PWM, SW_PWM};
			4'h6: r = {SW_PWM, SW_AUTO};
			4'h8: r = {SW_AUTO, SW_AUTO};
			4'h9: r = {SW_PWM, SW_SKIP};
			4'hA: r = {SW_SKIP, SW_SKIP};
			4'hB: r = {SW_SKIP, SW_AUTO};
			4'hC: r = {SW_AUTO, SW_PFM};
			4'hD: r = {SW_PWM, SW_PFM};
			4'hE: r = {SW_SKIP, SW_PFM};
			4'hF: r = {SW_PFM, SW_PFM};
			default: r = {SW_OFF, SW_OFF};  // unused code keeps the switcher off
		endcase
		return r;
	endfunction

	// effective switcher mode from code, sleep, low-power-off and load
	// low-power-off overrides the table; auto is resolved last so it never
	// reaches an output port
	function automatic sw_mode_t sw_resolve(input logic [3:0] code, input logic sleep,
		input logic lpoff, input logic retain, input logic load_high);
		logic [5:0] pair;
		sw_mode_t   m;
		pair = sw_decode(code);
		m    = sw_mode_t'(sleep ? pair[2:0] : pair[5:3]);
		if (lpoff)
			m = retain ? SW_PFM : SW_OFF;
		if (m == SW_AUTO)
			m = load_high ? SW_SKIP : SW_PFM;
		return m;
	endfunction

	// reset release through two flops
	// assertion reaches every flop at once; release is retimed to avoid a split start
	logic rst_meta_q;
	logic rst_n;
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// programmed settings
	// bit layout of each word follows the offsets and field positions of the header
	logic [6:0]        ctrl_q;
	logic [1:0]        events_q;
	logic [`N_ALL-1:0] reg_en_q;
	logic [`N_LP-1:0]  reg_lp_q;
	logic [`N_ALL-1:0] reg_sby_q;
	logic [19:0]       sw_mode_q;

	// bus decode
	// setup marks the first cycle of a transfer; writes commit on the ready edge
	// exact word match; any other address answers with an error
	wire setup     = PSEL_I & ~PENABLE_I;
	wire wr_commit = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
	wire hit_ctrl  = (PADDR_I == `ADDR_CTRL);
	wire hit_stat  = (PADDR_I == `ADDR_STATUS);
	wire hit_evt   = (PADDR_I == `ADDR_EVENTS);
	wire hit_en    = (PADDR_I == `ADDR_REG_EN);
	wire hit_lp    = (PADDR_I == `ADDR_REG_LP);
	wire hit_sby   = (PADDR_I == `ADDR_REG_SBY);
	wire hit_sw    = (PADDR_I == `ADDR_SW_MODE);
	wire hit_any   = hit_ctrl | hit_stat | hit_evt | hit_en | hit_lp | hit_sby | hit_sw;

	// field views
	wire [1:0] bsel  = ctrl_q[`CTRL_BSEL_LSB +: 2];
	wire [1:0] dly   = ctrl_q[`CTRL_DLY_LSB +: 2];
	wire       pinv  = ctrl_q[`CTRL_PINV_BIT];
	wire       sinv  = ctrl_q[`CTRL_SINV_BIT];
	wire       lpoff = ctrl_q[`CTRL_LPOFF_BIT];

	// battery flags and crossing events
	// the flops hold last cycle's levels; armed_q masks the first sample after reset
	logic above_low_q;
	logic above_weak_q;
	logic armed_q;
	wire  weak_cross = armed_q & (ABOVE_WEAK_I ^ above_weak_q);
	wire  low_drop   = above_low_q & ~ABOVE_LOW_I;
	wire  stat_low   = ~ABOVE_LOW_I;
	wire  stat_weak  = ABOVE_WEAK_I & ABOVE_LOW_I;
	wire  stat_pon   = ABOVE_PON_I & ABOVE_WEAK_I & ABOVE_LOW_I;

	// sleep request qualification
	// a pin counts as asserted when its level differs from its invert bit
	// low-power-off and any mode other than on hold the request down
	wire pri_act  = SLEEP_PIN_I ^ pinv;
	wire sec_act  = SECONDARY_SLEEP_PIN_I ^ sinv;
	wire sby_req  = pri_act & sec_act & ON_MODE_I & ~lpoff;

	// 32 kHz tick divider
	// count runs from zero to the divide ratio minus one
	// free-running, so the first delay period after a request is partial
	logic [11:0] div_q;
	wire         tick = (div_q == 12'(`SLOW_DIV - 1));
	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			div_q <= 12'h000;
		else
			div_q <= tick ? 12'h000 : div_q + 12'h001;
	end

	// sleep entry sequencer
	// the count is cleared while awake, so a dropped request leaves no credit
	// behind for the next one
	sby_state_t state_q;
	sby_state_t state_d;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_AWAKE:
			begin
				cnt_d = 2'b00;
				if (sby_req)
					state_d = (dly == 2'b00) ? ST_SLEEP : ST_WAIT;
			end
			ST_WAIT:
			begin
				if (!sby_req)
					state_d = ST_AWAKE;
				else if (tick)
				begin
					cnt_d = cnt_q + 2'b01;
					if (cnt_d == dly)
						state_d = ST_SLEEP;
				end
			end
			ST_SLEEP:
			begin
				if (!sby_req)
					state_d = ST_AWAKE;
			end
			default: state_d = ST_AWAKE;
		endcase
	end
	// sequencer state register
	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_AWAKE;
			cnt_q   <= 2'b00;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end
	// effective sleep drops in the same cycle as the request
	wire sleep = (state_q == ST_SLEEP) & sby_req; // exit without waiting a cycle

	// regulator and general output resolution
	// low-power regulators keep low-power in sleep; only their on state is cut
	wire [`N_ALL-1:0] cut    = reg_sby_q & {`N_ALL{sleep}};
	wire [`N_LP-1:0]  lp_on  = reg_en_q[`N_LP-1:0] & ~reg_lp_q & ~cut[`N_LP-1:0];
	wire [`N_LP-1:0]  lp_low = reg_en_q[`N_LP-1:0] & reg_lp_q;
	wire [`N_ALL-`N_LP-1:0] simple_on =
		reg_en_q[`N_ALL-1:`N_LP] & ~cut[`N_ALL-1:`N_LP];

	// switcher resolution
	// load and low-power-off levels are used as they arrive
	wire [`N_SW-1:0] ret = sw_mode_q[`SW_RET_LSB +: `N_SW];
	wire sw_mode_t sw0 = sw_resolve(sw_mode_q[3:0], sleep, LP_OFF_STATE_I, ret[0], LOAD_HIGH_I[0]);
	wire sw_mode_t sw1 = sw_resolve(sw_mode_q[7:4], sleep, LP_OFF_STATE_I, ret[1], LOAD_HIGH_I[1]);
	wire sw_mode_t sw2 = sw_resolve(sw_mode_q[11:8], sleep, LP_OFF_STATE_I, ret[2], LOAD_HIGH_I[2]);
	wire sw_mode_t sw3 = sw_resolve(sw_mode_q[15:12], sleep, LP_OFF_STATE_I, ret[3], LOAD_HIGH_I[3]);

	// read mux, programmed values, live status and event flags
	// sleep modification never reaches the readback of a setting
	wire [31:0] rd_data =
		hit_ctrl ? {25'h000_0000, ctrl_q} :
		hit_stat ? {27'h000_0000, sby_req, sleep, stat_low, stat_weak, stat_pon} :
		hit_evt  ? {30'h0000_0000, events_q} :
		hit_en   ? {16'h0000, reg_en_q} :
		hit_lp   ? {26'h000_0000, reg_lp_q} :
		hit_sby  ? {16'h0000, reg_sby_q} :
		hit_sw   ? {12'h000, sw_mode_q} :
		32'h0000_0000;

	// event flags: a new event wins over a clearing write
	// write one to clear; the clear acts only on a committed write
	wire [1:0] evt_new = {low_drop, weak_cross};
	wire [1:0] evt_clr = (wr_commit & hit_evt) ? PWDATA_I[1:0] : 2'b00;
	wire [1:0] evt_d   = (events_q & ~evt_clr) | evt_new;

	// register file
	// writes land on the access edge with ready high
	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q    <= `CTRL_RESET;
			events_q  <= 2'b00;
			reg_en_q  <= 16'h0000;
			reg_lp_q  <= 6'h00;
			reg_sby_q <= 16'h0000;
			sw_mode_q <= 20'h0_0000;
		end
		else
		begin
			events_q <= evt_d;
			if (wr_commit & hit_ctrl)
				ctrl_q <= PWDATA_I[6:0];
			if (wr_commit & hit_en)
				reg_en_q <= PWDATA_I[15:0];
			if (wr_commit & hit_lp)
				reg_lp_q <= PWDATA_I[5:0];
			if (wr_commit & hit_sby)
				reg_sby_q <= PWDATA_I[15:0];
			if (wr_commit & hit_sw)
				sw_mode_q <= PWDATA_I[19:0];
		end
	end

	// bus answer: one access cycle, loaded at setup
	// ready never stretches, so every transfer takes exactly one access cycle
	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			PRDATA_O  <= 32'h0000_0000;
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
		end
		else
		begin
			PREADY_O  <= setup;
			PSLVERR_O <= setup & ~hit_any;
			if (setup)
				PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_data;
		end
	end

	// registered block outputs
	// every port is a flop; supply states lag their settings by one cycle
	// armed_q rises one edge after reset so the first comparator sample is not an edge
	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			above_low_q                <= 1'b0;
			above_weak_q               <= 1'b0;
			armed_q                    <= 1'b0;
			BATTERY_THRESHOLD_SELECT_O <= 2'b00;
			WEAK_BATTERY_INTERRUPT_O   <= 1'b0;
			LOW_BATTERY_INTERRUPT_O    <= 1'b0;
			DEEP_SLEEP_MODE_O          <= 1'b0;
			LOW_POWER_OFF_COMMAND_O    <= 1'b0;
			LP_REG_ON_O                <= 6'h00;
			LP_REG_LOW_POWER_O         <= 6'h00;
			SIMPLE_OUT_ON_O            <= 10'h000;
			SW0_OP_O                   <= SW_OFF;
			SW1_OP_O                   <= SW_OFF;
			SW2_OP_O                   <= SW_OFF;
			SW3_OP_O                   <= SW_OFF;
		end
		else
		begin
			above_low_q                <= ABOVE_LOW_I;
			above_weak_q               <= ABOVE_WEAK_I;
			armed_q                    <= 1'b1;
			BATTERY_THRESHOLD_SELECT_O <= bsel;
			WEAK_BATTERY_INTERRUPT_O   <= weak_cross;
			LOW_BATTERY_INTERRUPT_O    <= low_drop;
			DEEP_SLEEP_MODE_O          <= sleep;
			LOW_POWER_OFF_COMMAND_O    <= lpoff;
			LP_REG_ON_O                <= lp_on;
			LP_REG_LOW_POWER_O         <= lp_low;
			SIMPLE_OUT_ON_O            <= simple_on;
			SW0_OP_O                   <= sw0;
			SW1_OP_O                   <= sw1;
			SW2_OP_O                   <= sw2;
			SW3_OP_O                   <= sw3;
		end
	end
endmodule
`default_nettype wire
